// File: core/pmvp_port.sv
`timescale 1ns/100ps
// ------------------------------------------------------------------
// sample fifo
// ------------------------------------------------------------------
module pmvp_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   // pointers one bit wider than the address tell full from empty
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_r [DEPTH];
   logic [AW:0] wr_r;
   logic [AW:0] rd_r;
   logic [AW:0] used;
   wire push;
   wire pop;

   assign used = wr_r - rd_r;
   assign in_ready = (used != (AW + 1)'(DEPTH));
   assign out_valid = (used != '0);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem_r[rd_r[AW-1:0]];

   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_r[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         wr_r <= wr_r + (AW + 1)'(push);
         rd_r <= rd_r + (AW + 1)'(pop);
      end
   end
endmodule

// ------------------------------------------------------------------
// voice port, master towards the codec
// ------------------------------------------------------------------
module pmvp_port #(
   parameter int DEPTH = pmvp_pkg::FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clk_link,
   input wire logic [pmvp_pkg::SAMPLE_W-1:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic tx_underrun,
   output logic [pmvp_pkg::SAMPLE_W-1:0] rx_data,
   output logic rx_valid,
   input wire logic pcm_clk_in,
   output logic pcm_clk_out,
   output logic pcm_clk_oe,
   input wire logic pcm_sync_in,
   output logic pcm_sync_out,
   output logic pcm_sync_oe,
   input wire logic pcm_in,
   output logic pcm_out,
   output logic pcm_out_oe
);
   import pmvp_pkg::*;

   // ---------------------------------------------------------------
   // system side: transmit fifo and word handover
   // ---------------------------------------------------------------
   logic [SAMPLE_W-1:0] fifo_data;
   logic fifo_valid;
   logic need_s1_r;
   logic need_s2_r;
   logic need_s3_r;
   logic need_ev;
   logic ack_tgl_r;
   logic [SAMPLE_W-1:0] tx_hold_r;
   logic [SAMPLE_W-1:0] tx_hold_nxt;
   logic underrun_r;
   logic need_tgl_r;

   pmvp_fifo #(
      .W(SAMPLE_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk(clk_sys),
      .rst(sys_rst),
      .in_data(tx_data),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(need_ev)
   );

   assign need_ev = need_s2_r ^ need_s3_r;
   assign tx_hold_nxt = fifo_valid ? fifo_data : TX_IDLE;

   // request toggle from the link side, two flops then edge detect
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         need_s1_r <= 1'b0;
         need_s2_r <= 1'b0;
         need_s3_r <= 1'b0;
      end else begin
         need_s1_r <= need_tgl_r;
         need_s2_r <= need_s1_r;
         need_s3_r <= need_s2_r;
      end
   end

   // word handover: data is stable before its toggle arrives
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ack_tgl_r <= 1'b0;
         tx_hold_r <= TX_IDLE;
         underrun_r <= 1'b0;
      end else begin
         underrun_r <= need_ev & ~fifo_valid;
         if (need_ev) begin
            tx_hold_r <= tx_hold_nxt;
            ack_tgl_r <= ~ack_tgl_r;
         end
      end
   end

   assign tx_underrun = underrun_r;

   // ---------------------------------------------------------------
   // system side: receive word delivery
   // ---------------------------------------------------------------
   logic rx_tgl_r;
   logic [SAMPLE_W-1:0] rx_cap_r;
   logic rx_s1_r;
   logic rx_s2_r;
   logic rx_s3_r;
   logic rx_ev;
   logic [SAMPLE_W-1:0] rx_data_r;
   logic rx_valid_r;

   assign rx_ev = rx_s2_r ^ rx_s3_r;

   // word toggle from the link side, two flops then edge detect
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rx_s1_r <= 1'b0;
         rx_s2_r <= 1'b0;
         rx_s3_r <= 1'b0;
      end else begin
         rx_s1_r <= rx_tgl_r;
         rx_s2_r <= rx_s1_r;
         rx_s3_r <= rx_s2_r;
      end
   end

   // captured word is stable before its toggle arrives
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rx_data_r <= '0;
         rx_valid_r <= 1'b0;
      end else begin
         rx_valid_r <= rx_ev;
         if (rx_ev) begin
            rx_data_r <= rx_cap_r;
         end
      end
   end

   assign rx_data = rx_data_r;
   assign rx_valid = rx_valid_r;

   // ---------------------------------------------------------------
   // link side: reset and crossings
   // ---------------------------------------------------------------
   logic lrst_s1_r;
   logic lrst_r;
   logic ack_s1_r;
   logic ack_s2_r;
   logic ack_s3_r;
   logic ack_ev;
   logic din_s1_r;
   logic din_s2_r;

   always_ff @(posedge clk_link) begin
      lrst_s1_r <= sys_rst;
      lrst_r <= lrst_s1_r;
      din_s1_r <= pcm_in;
      din_s2_r <= din_s1_r;
   end

   always_ff @(posedge clk_link) begin
      if (lrst_r) begin
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
         ack_s3_r <= 1'b0;
      end else begin
         ack_s1_r <= ack_tgl_r;
         ack_s2_r <= ack_s1_r;
         ack_s3_r <= ack_s2_r;
      end
   end

   assign ack_ev = ack_s2_r ^ ack_s3_r;

   // ---------------------------------------------------------------
   // link side: bit clock and frame timing
   // ---------------------------------------------------------------
   logic [PH_W-1:0] ph_r;
   logic [BIT_W-1:0] bit_r;
   logic [BIT_W-1:0] bit_nxt;
   logic rise_ev;
   logic fall_ev;
   logic capt_ev;
   logic in_slot;
   logic nxt_in_slot;
   logic bclk_r;
   logic sync_r;
   logic drive_r;

   assign rise_ev = (ph_r == PH_RISE);
   assign fall_ev = (ph_r == PH_FALL);
   assign capt_ev = (ph_r == PH_CAPT);
   assign bit_nxt = bit_r + BIT_W'(1);
   assign in_slot = (bit_r <= BIT_LAST);
   assign nxt_in_slot = (bit_nxt <= BIT_LAST);

   // clock and sync pins driven as master once the link leaves reset
   always_ff @(posedge clk_link) begin
      if (lrst_r) begin
         drive_r <= 1'b0;
      end else begin
         drive_r <= 1'b1;
      end
   end

   // bit clock: 8 link cycles high, 8 low
   always_ff @(posedge clk_link) begin
      if (lrst_r) begin
         ph_r <= PH_FALL;
         bclk_r <= 1'b0;
      end else begin
         ph_r <= ph_r + PH_W'(1);
         if (rise_ev) begin
            bclk_r <= 1'b1;
         end else if (fall_ev) begin
            bclk_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_link) begin
      if (lrst_r) begin
         bit_r <= BIT_W'(BITS_PER_FRAME - 1);
         sync_r <= 1'b0;
      end else if (rise_ev) begin
         bit_r <= bit_nxt;
         sync_r <= (bit_nxt == BIT_FIRST);
      end
   end

   assign pcm_clk_out = bclk_r;
   assign pcm_clk_oe = drive_r;
   assign pcm_sync_out = sync_r;
   assign pcm_sync_oe = drive_r;

   // ---------------------------------------------------------------
   // link side: transmit shifter
   // ---------------------------------------------------------------
   logic [SAMPLE_W-1:0] tx_next_r;
   logic [SAMPLE_W-1:0] tx_sh_r;
   logic dout_r;
   logic dout_oe_r;

   always_ff @(posedge clk_link) begin
      if (lrst_r) begin
         tx_next_r <= TX_IDLE;
         need_tgl_r <= 1'b0;
      end else begin
         if (ack_ev) begin
            tx_next_r <= tx_hold_r;
         end
         if (rise_ev && bit_nxt == BIT_REQ) begin
            need_tgl_r <= ~need_tgl_r;
         end
      end
   end

   always_ff @(posedge clk_link) begin
      if (lrst_r) begin
         tx_sh_r <= TX_IDLE;
         dout_r <= 1'b0;
         dout_oe_r <= 1'b0;
      end else if (rise_ev && nxt_in_slot) begin
         if (bit_nxt == BIT_FIRST) begin
            dout_r <= tx_next_r[SAMPLE_W-1];
            tx_sh_r <= {tx_next_r[SAMPLE_W-2:0], 1'b0};
         end else begin
            dout_r <= tx_sh_r[SAMPLE_W-1];
            tx_sh_r <= {tx_sh_r[SAMPLE_W-2:0], 1'b0};
         end
         dout_oe_r <= 1'b1;
      end else if (fall_ev && bit_r == BIT_LAST) begin
         dout_oe_r <= 1'b0;
      end
   end

   assign pcm_out = dout_r;
   assign pcm_out_oe = dout_oe_r;

   // ---------------------------------------------------------------
   // link side: receive shifter
   // ---------------------------------------------------------------
   logic [SAMPLE_W-1:0] rx_sh_r;
   logic [SAMPLE_W-1:0] rx_sh_nxt;

   // data seen here left the pin at the falling edge, SYNC_LAT ago
   assign rx_sh_nxt = {rx_sh_r[SAMPLE_W-2:0], din_s2_r};

   always_ff @(posedge clk_link) begin
      if (lrst_r) begin
         rx_sh_r <= '0;
         rx_cap_r <= '0;
         rx_tgl_r <= 1'b0;
      end else if (capt_ev && in_slot) begin
         rx_sh_r <= rx_sh_nxt;
         if (bit_r == BIT_LAST) begin
            rx_cap_r <= rx_sh_nxt;
            rx_tgl_r <= ~rx_tgl_r;
         end
      end
   end
endmodule

// File: core/pmvp_pkg.sv
package pmvp_pkg;
   // ---------------------------------------------------------------
   // link timing
   // ---------------------------------------------------------------
   localparam int BCLK_HZ = 2_048_000;
   localparam int LINK_HZ = 32_768_000;
   localparam int FRAME_HZ = 8_000;
   localparam int T_BCLK_NS = 488;
   localparam int T_BCLK_HI_NS = 244;
   localparam int T_FRAME_US = 125;
   localparam int T_SYNC_HI_NS = 488;
   localparam int T_SYNC_OFS_NS = 122;
   localparam int SAMPLE_W = 16;
   localparam int BITS_PER_FRAME = BCLK_HZ / FRAME_HZ;
   localparam int LINK_DIV = LINK_HZ / BCLK_HZ;
   localparam int SYNC_LAT = 2;
   localparam int FIFO_DEPTH = 8;
   // ---------------------------------------------------------------
   // phase and bit positions
   // ---------------------------------------------------------------
   localparam int PH_W = $clog2(LINK_DIV);
   localparam int BIT_W = $clog2(BITS_PER_FRAME);
   localparam logic [PH_W-1:0] PH_RISE = PH_W'(LINK_DIV - 1);
   localparam logic [PH_W-1:0] PH_FALL = PH_W'(LINK_DIV / 2 - 1);
   localparam logic [PH_W-1:0] PH_CAPT = PH_W'(LINK_DIV / 2 - 1 + SYNC_LAT);
   localparam logic [BIT_W-1:0] BIT_FIRST = '0;
   localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(SAMPLE_W - 1);
   localparam logic [BIT_W-1:0] BIT_REQ = BIT_W'(SAMPLE_W);
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [SAMPLE_W-1:0] TX_IDLE = 16'h0000;
endpackage

// File: verif/pmvp_port_monitor.sv
`timescale 1ns/100ps
// ----------------------------------------------------------
// link and stream checker
// ----------------------------------------------------------
module pmvp_port_monitor (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clk_link,
   input wire logic [pmvp_pkg::SAMPLE_W-1:0] rx_data,
   input wire logic rx_valid,
   input wire logic pcm_clk_out,
   input wire logic pcm_sync_out,
   input wire logic pcm_out,
   input wire logic pcm_out_oe
);
   import pmvp_pkg::*;
   logic [4:0] sync_cnt_r;
   logic [12:0] gap_r;
   // sync high length and sync to sync spacing in link cycles
   always_ff @(posedge clk_link) begin
      if (sys_rst) begin
         sync_cnt_r <= 5'h00;
         gap_r <= 13'h0000;
      end else begin
         sync_cnt_r <= pcm_sync_out ? sync_cnt_r + 5'h01 : 5'h00;
         gap_r <= $rose(pcm_sync_out) ? 13'h0001 :
            (gap_r != 13'h0000 ? gap_r + 13'h0001 : 13'h0000);
      end
   end
   property p_clk_hi;
      @(posedge clk_link) disable iff (sys_rst)
      $rose(pcm_clk_out) |-> pcm_clk_out [*8] ##1 !pcm_clk_out;
   endproperty
   a_clk_hi: assert property (p_clk_hi) else $error("clk high");
   property p_clk_lo;
      @(posedge clk_link) disable iff (sys_rst)
      $fell(pcm_clk_out) |-> !pcm_clk_out [*8] ##1 pcm_clk_out;
   endproperty
   a_clk_lo: assert property (p_clk_lo) else $error("clk low");
   property p_sync_edge;
      @(posedge clk_link) disable iff (sys_rst)
      $changed(pcm_sync_out) |-> $rose(pcm_clk_out);
   endproperty
   a_sync_edge: assert property (p_sync_edge) else $error("sync");
   property p_sync_len;
      @(posedge clk_link) disable iff (sys_rst)
      $fell(pcm_sync_out) |-> sync_cnt_r == 5'h10;
   endproperty
   a_sync_len: assert property (p_sync_len) else $error("sync len");
   property p_frame;
      @(posedge clk_link) disable iff (sys_rst)
      $rose(pcm_sync_out) && gap_r != 13'h0000 |-> gap_r == 13'h1000;
   endproperty
   a_frame: assert property (p_frame) else $error("frame");
   property p_oe_start;
      @(posedge clk_link) disable iff (sys_rst)
      $rose(pcm_out_oe) |-> $rose(pcm_clk_out) && pcm_sync_out;
   endproperty
   a_oe_start: assert property (p_oe_start) else $error("oe");
   property p_oe_len;
      @(posedge clk_link) disable iff (sys_rst)
      $rose(pcm_out_oe) |-> ##247 pcm_out_oe ##1 !pcm_out_oe;
   endproperty
   a_oe_len: assert property (p_oe_len) else $error("oe len");
   property p_out_edge;
      @(posedge clk_link) disable iff (sys_rst)
      pcm_out_oe && $changed(pcm_out) |-> $rose(pcm_clk_out);
   endproperty
   a_out_edge: assert property (p_out_edge) else $error("out");
   property p_rx_hold;
      @(posedge clk_sys) disable iff (sys_rst)
      $changed(rx_data) |-> rx_valid;
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("rx");
   c_sync: cover property (@(posedge clk_link) $rose(pcm_sync_out));
   c_oe: cover property (@(posedge clk_link) $fell(pcm_out_oe));
   c_rx: cover property (@(posedge clk_sys) rx_valid);
endmodule

bind pmvp_port pmvp_port_monitor i_mon (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_link(clk_link),
   .rx_data(rx_data), .rx_valid(rx_valid), .pcm_clk_out(pcm_clk_out),
   .pcm_sync_out(pcm_sync_out), .pcm_out(pcm_out), .pcm_out_oe(pcm_out_oe)
);

// File: verif/pmvp_codec_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------
// codec slave model
// ----------------------------------------------------------
module pmvp_codec_model (
   input wire logic bclk,
   input wire logic sync,
   input wire logic din,
   input wire logic [15:0] tx_word,
   output logic dout,
   output logic [15:0] rx_word,
   output int rx_cnt
);
   int idx = 99;
   logic din_q;
   initial begin
      dout = 1'b0;
      rx_cnt = 0;
   end
   // launch just after the rising edge, toggling outside the slot
   always @(posedge bclk) begin
      #1;
      idx = (sync === 1'b1) ? 0 : idx + 1;
      dout = (idx < 16) ? tx_word[15 - idx] : ~dout;
      din_q = din;
   end
   // bit held since launch, so release at the fall cannot race it
   always @(negedge bclk) begin
      if (idx < 16)
         rx_word[15 - idx] = din_q;
      if (idx == 15)
         rx_cnt++;
   end
endmodule

// File: verif/pmvp_port_tb.sv
`timescale 1ns/100ps
module pmvp_port_tb;
   import pmvp_pkg::*;
   logic clk_sys = 1'b0, clk_link = 1'b0, sys_rst = 1'b1, tx_valid = 1'b0;
   logic [15:0] tx_data = 16'h0000, c_word = 16'h4c72, rx_data, m_word;
   logic tx_ready, tx_underrun, rx_valid, ck, ck_oe, sy, sy_oe, po, po_oe;
   logic pin;
   int rx_cnt, und = 0, error_cnt = 0, num_checks = 0;
   wire logic ck_pin = ck_oe ? ck : 1'bz;
   wire logic sy_pin = sy_oe ? sy : 1'bz;
   wire logic d_pin = po_oe ? po : 1'bz;
   pmvp_port #(.DEPTH(8)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .clk_link(clk_link), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_underrun(tx_underrun), .rx_data(rx_data),
      .rx_valid(rx_valid), .pcm_clk_in(ck_pin), .pcm_clk_out(ck),
      .pcm_clk_oe(ck_oe), .pcm_sync_in(sy_pin), .pcm_sync_out(sy),
      .pcm_sync_oe(sy_oe), .pcm_in(pin), .pcm_out(po), .pcm_out_oe(po_oe));
   pmvp_codec_model i_codec (.bclk(ck_pin), .sync(sy_pin), .din(d_pin),
      .tx_word(c_word), .dout(pin), .rx_word(m_word), .rx_cnt(rx_cnt));
   initial forever #25 clk_sys = ~clk_sys;
   initial begin
      #7;
      forever #16 clk_link = ~clk_link;
   end
   always @(posedge clk_sys) if (tx_underrun === 1'b1) und++;
   function automatic logic [15:0] pat(input int k, input logic [15:0] b);
      return b + 16'(k) * 16'h1357;
   endfunction
   task automatic tick;
      @(posedge clk_sys);
      #2;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      if (error_cnt == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic wait_frame;
      int n0;
      n0 = rx_cnt;
      for (int i = 0; i < 3000 && rx_cnt == n0; i++) tick;
      chk(16'(rx_cnt - n0), 16'h0001);
   endtask
   // eight words fill the fifo, the ninth is refused
   task automatic t_fill;
      tx_valid = 1'b1;
      for (int i = 0; i < 9; i++) begin
         tx_data = pat(i, 16'h8001);
         chk(16'(tx_ready), (i < 8) ? 16'h0001 : 16'h0000);
         tick;
      end
      tx_valid = 1'b0;
   endtask
   // both directions per frame, then an underrun sends zero
   task automatic t_stream;
      for (int k = 0; k < 10; k++) begin
         wait_frame;
         chk(m_word, (k == 0 || k == 9) ? 16'h0 :
            pat(k - 1, 16'h8001));
         chk(16'(und), (k == 9) ? 16'h0001 : 16'h0000);
         for (int i = 0; i < 20 && rx_valid !== 1'b1; i++) tick;
         chk(rx_data, pat(k, 16'h4c72));
         c_word = pat(k + 1, 16'h4c72);
      end
   endtask
   // reset in mid-run, then the link restarts with a zero sample
   task automatic t_reset;
      sys_rst = 1'b1;
      repeat (20) tick;
      chk(16'({ck_oe, po_oe, rx_valid, tx_ready}), 16'h0001);
      sys_rst = 1'b0;
      wait_frame;
      chk(m_word, 16'h0000);
      chk(16'({ck_oe, sy_oe}), 16'h0003);
   endtask
   initial begin
      #3000000;
      error_cnt++;
      final_report;
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      #2;
      sys_rst = 1'b0;
      t_fill;
      t_stream;
      t_reset;
      final_report;
   end
endmodule
